// ---- shared/lsdpc_params.svh ----
// Offsets, field positions, reset values and timing counts of the driver control block
`ifndef LSDPC_PARAMS_SVH
`define LSDPC_PARAMS_SVH

`define LSDPC_CLK_PERIOD_NS   10
`define LSDPC_OFF_CTRL        8'h00
`define LSDPC_OFF_MAP         8'h04
`define LSDPC_OFF_CFG2        8'h08
`define LSDPC_OFF_DIAG        8'h0c
`define LSDPC_OFF_OSM         8'h10
`define LSDPC_OFF_RELEASE     8'h14
`define LSDPC_CTRL_PAIR_EVEN  4
`define LSDPC_CTRL_PAIR_ODD   5
`define LSDPC_CTRL_THR_SEL    6
`define LSDPC_CTRL_SOFT_RST   7
`define LSDPC_MAP_DEFAULT     8'h84
`define LSDPC_CFG2_FAST_SLEW  0
`define LSDPC_CFG2_TEMP_WARN  1
`define LSDPC_DIAG_UV         4
`define LSDPC_DIAG_OL_OFF     5
`define LSDPC_DIAG_FRAME_ERR  8
`define LSDPC_RETRY_BASE_MS   10
`define LSDPC_RETRY_BASE_CYC  (`LSDPC_RETRY_BASE_MS * 1000000 / `LSDPC_CLK_PERIOD_NS)
`define LSDPC_RETRY_PER_STEP  8
`define LSDPC_RETRY_STEPS     3
`define LSDPC_TSYNC_US        100
`define LSDPC_SYNC2_CYC       (2 * `LSDPC_TSYNC_US * 1000 / `LSDPC_CLK_PERIOD_NS)
`define LSDPC_INRUSH_US       200
`define LSDPC_INRUSH_CYC      (`LSDPC_INRUSH_US * 1000 / `LSDPC_CLK_PERIOD_NS)
`define LSDPC_OFF_OCP_US      5
`define LSDPC_OFF_OCP_CYC     (`LSDPC_OFF_OCP_US * 1000 / `LSDPC_CLK_PERIOD_NS)

`endif

// ---- shared/lsdpc_pkg.sv ----
// Types shared by the driver control block
package lsdpc_pkg;
  typedef enum logic [1:0] {
    LSDPC_MODE_NORMAL,
    LSDPC_MODE_FAILSAFE
  } lsdpc_mode_type;

  typedef struct packed {
    logic [3:0] oc_high;
    logic [3:0] oc_low;
    logic [3:0] over_temp;
    logic [3:0] vds_low;
  } lsdpc_sense_type;
endpackage : lsdpc_pkg

// ---- rtl/lsdpc_channel.sv ----
// One output channel: overcurrent filter, inrush threshold and protection latch
`timescale 1ns/1ps
`default_nettype none
module lsdpc_channel #(
  parameter int unsigned SYNC2_CYC   = 2,
  parameter int unsigned INRUSH_CYC  = 2,
  parameter int unsigned OFF_OCP_CYC = 2
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic demand_i,
  input  wire logic oc_high_i,
  input  wire logic oc_low_i,
  input  wire logic over_temp_i,
  input  wire logic release_i,
  input  wire logic partner_trip_i,
  output logic      gate_o,
  output logic      trip_o,
  output logic      latched_o,
  output logic      high_thr_o
);
  logic [23:0] off_cnt_reg;
  logic [23:0] on_cnt_reg;
  logic [23:0] flt_cnt_reg;
  logic        over;

  assign over       = high_thr_o ? oc_high_i : oc_low_i;
  assign trip_o     = gate_o & (over_temp_i | (over & (flt_cnt_reg == 24'(OFF_OCP_CYC - 1)))); // R15 R19

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      latched_o <= 1'b0;
    end else if (trip_o | partner_trip_i) begin
      latched_o <= 1'b1; // R15 R12
    end else if (release_i) begin
      latched_o <= 1'b0; // R15
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      gate_o <= 1'b0;
    end else begin
      gate_o <= demand_i & ~latched_o & ~trip_o & ~partner_trip_i; // R19
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i | ~gate_o | ~over) begin
      flt_cnt_reg <= '0;
    end else if (flt_cnt_reg != 24'(OFF_OCP_CYC - 1)) begin
      flt_cnt_reg <= flt_cnt_reg + 24'h000001; // R19
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      off_cnt_reg <= '0;
      on_cnt_reg  <= '0;
      high_thr_o  <= 1'b1;
    end else if (gate_o) begin
      off_cnt_reg <= '0;
      if (on_cnt_reg == 24'(INRUSH_CYC - 1)) begin
        high_thr_o <= 1'b0; // R18
      end else begin
        on_cnt_reg <= on_cnt_reg + 24'h000001;
      end
    end else begin
      on_cnt_reg <= '0;
      if (off_cnt_reg == 24'(SYNC2_CYC)) begin
        high_thr_o <= 1'b1; // R18
      end else begin
        off_cnt_reg <= off_cnt_reg + 24'h000001;
      end
    end
  end
endmodule : lsdpc_channel
`default_nettype wire

// ---- rtl/lsdpc_retry.sv ----
// Fail-safe restart timer for one channel
`timescale 1ns/1ps
`default_nettype none
`include "lsdpc_params.svh"
module lsdpc_retry #(
  parameter int unsigned BASE_CYC  = 2,
  parameter int unsigned SYNC2_CYC = 2
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic enable_i,
  input  wire logic input_high_i,
  input  wire logic latched_i,
  output logic      retry_o
);
  logic [23:0] low_cnt_reg;
  logic [23:0] int_cnt_reg;
  logic [4:0]  tries_reg;
  logic [1:0]  step;
  logic [23:0] interval;
  logic        timer_clear;

  assign step        = (tries_reg >= 5'(`LSDPC_RETRY_PER_STEP * `LSDPC_RETRY_STEPS)) ? 2'h3 :
                       2'(tries_reg / 5'(`LSDPC_RETRY_PER_STEP));
  assign interval    = 24'(BASE_CYC) << step; // R21
  assign timer_clear = rst_i | ~enable_i | (low_cnt_reg == 24'(SYNC2_CYC)); // R22
  assign retry_o     = enable_i & input_high_i & latched_i & (int_cnt_reg == interval - 24'h000001);

  always_ff @(posedge clk_i) begin
    if (rst_i | input_high_i) begin
      low_cnt_reg <= '0;
    end else if (low_cnt_reg != 24'(SYNC2_CYC)) begin
      low_cnt_reg <= low_cnt_reg + 24'h000001;
    end
  end

  always_ff @(posedge clk_i) begin
    if (timer_clear | ~input_high_i | ~latched_i | retry_o) begin
      int_cnt_reg <= '0;
    end else begin
      int_cnt_reg <= int_cnt_reg + 24'h000001; // R21
    end
  end

  always_ff @(posedge clk_i) begin
    if (timer_clear) begin
      tries_reg <= '0; // R22
    end else if (retry_o && tries_reg != 5'(`LSDPC_RETRY_PER_STEP * `LSDPC_RETRY_STEPS)) begin
      tries_reg <= tries_reg + 5'h01; // R21
    end
  end
endmodule : lsdpc_retry
`default_nettype wire

// ---- rtl/lsdpc_top.sv ----
// Control logic of the four-channel low-side switch with Wishbone register access
// How it works
// R1 - Sleep pin low with any input high enters fail-safe and drives that input's channel.
// R2 - In fail-safe, reads are answered and every register write is dropped.
// R3 - Fail-safe entry sets the undervoltage flag and shows mode 01b.
// R4 - Frame error flag is forced to one on the first access after fail-safe entry.
// R5 - In fail-safe the open-load summary reads zero; fault and monitor bits work.
// R6 - Other registers stay at defaults and cannot be written during fail-safe.
// R7 - In fail-safe only channels 2 and 3 run, each from its input pin.
// R8 - Logic undervoltage, sleep pin low or soft reset restore register defaults.
// R9 - Soft reset keeps the channel fault flags.
// R10 - Register reset turns off channels not held by inputs and restores the mapping.
// R11 - Slew is slow by default; the fast-slew bit selects the fast rate.
// R12 - With pairing on, a tripping channel also shuts down its partner.
// R13 - Even pairing bit couples channels 0 and 2, odd bit couples 1 and 3.
// R14 - Pairing changes only the fault reaction; software switches pairs together.
// R15 - Overcurrent or overtemperature sets the fault flag and latches the channel off.
// R16 - The release bit clears itself once the latch is released.
// R17 - Load undervoltage sets its flag; it clears on diagnosis read once supply recovers.
// R18 - High threshold during inrush, low afterwards; long off time restores high.
// R19 - Current above threshold for the filter time turns the channel off, sets flag.
// R20 - Thermal warning flag sets above the warning point, clears below hysteresis.
// R21 - Fail-safe retries: 8 at 10 ms, 8 at 20 ms, 8 at 40 ms, then 80 ms.
// R22 - Input low over two sync periods resets the retry timer.
`timescale 1ns/1ps
`default_nettype none
`include "lsdpc_params.svh"
module lsdpc_top
  import lsdpc_pkg::*;
#(
  parameter int unsigned RETRY_BASE_CYC = `LSDPC_RETRY_BASE_CYC,
  parameter int unsigned SYNC2_CYC      = `LSDPC_SYNC2_CYC,
  parameter int unsigned INRUSH_CYC     = `LSDPC_INRUSH_CYC,
  parameter int unsigned OFF_OCP_CYC    = `LSDPC_OFF_OCP_CYC
) (
  input  wire logic            clk_i,
  input  wire logic            rst_i,
  input  wire logic            cyc_i,
  input  wire logic            stb_i,
  input  wire logic            we_i,
  input  wire logic [7:0]      adr_i,
  input  wire logic [3:0]      sel_i,
  input  wire logic [31:0]     dat_i,
  output logic [31:0]          dat_o,
  output logic                 ack_o,
  input  wire logic            sleep_bar_pin_i,
  input  wire logic [1:0]      direct_input_pin_i,
  input  wire logic            vdd_uv_i,
  input  wire logic            vm_uv_i,
  input  wire logic            vm_op_i,
  input  wire logic            temp_above_warn_i,
  input  wire logic            temp_below_hys_i,
  input  wire logic            frame_error_i,
  input  wire lsdpc_sense_type sense_i,
  output logic [3:0]           channel_gate_o,
  output logic [3:0]           high_threshold_o,
  output logic                 overload_threshold_select_o,
  output logic                 fast_slew_select_o,
  output lsdpc_mode_type       mode_o
);
  //////////////////////////////
  // Register state
  logic [3:0]  channel_on_bit_reg;
  logic        pair_even_sync_reg;
  logic        pair_odd_sync_reg;
  logic        thr_sel_reg;
  logic        soft_rst_reg;
  logic [7:0]  map_reg;
  logic        fast_slew_reg;
  logic [3:0]  iol_en_reg;
  logic        thermal_warning_flag_reg;
  logic [3:0]  channel_fault_flag_reg;
  logic        uv_flag_reg;
  logic        frame_error_flag_reg;
  logic        frame_err_pending_reg;
  logic [3:0]  output_monitor_bit_reg;
  logic [3:0]  latch_release_bit_reg;
  logic        failsafe_reg;

  logic        failsafe;
  logic        failsafe_entry;
  logic        reg_rst;
  logic        flag_rst;
  logic        access;
  logic        wr;
  logic        rd_diag;
  logic        open_load_off_summary;
  logic [3:0]  demand;
  logic [3:0]  trip;
  logic [3:0]  latched;
  logic [3:0]  retry;
  logic [3:0]  partner_trip;
  logic [3:0]  pair_mask;

  function automatic logic [3:0] lsdpc_input_map(input logic [7:0] map, input logic [1:0] pins);
    lsdpc_input_map = (map[3:0] & {4{pins[0]}}) | (map[7:4] & {4{pins[1]}});
  endfunction : lsdpc_input_map

  function automatic logic hit(input logic [7:0] adr, input logic [7:0] off);
    hit = (adr == off);
  endfunction : hit

  //////////////////////////////
  // Mode and reset conditions
  assign failsafe       = ~sleep_bar_pin_i & (|direct_input_pin_i); // R1
  assign failsafe_entry = failsafe & ~failsafe_reg;
  assign reg_rst        = rst_i | vdd_uv_i | ~sleep_bar_pin_i | soft_rst_reg; // R8 R6
  assign flag_rst       = rst_i | vdd_uv_i; // R9
  assign mode_o         = failsafe ? LSDPC_MODE_FAILSAFE : LSDPC_MODE_NORMAL; // R3

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      failsafe_reg <= 1'b0;
    end else begin
      failsafe_reg <= failsafe;
    end
  end

  //////////////////////////////
  // Wishbone slave
  assign access  = cyc_i & stb_i & ~ack_o;
  assign wr      = access & we_i & ~failsafe; // R2
  assign rd_diag = access & ~we_i & hit(adr_i, `LSDPC_OFF_DIAG);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
    end else begin
      ack_o <= access;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_o <= '0;
    end else if (access & ~we_i) begin
      dat_o <= '0;
      case (adr_i)
        `LSDPC_OFF_CTRL: begin
          dat_o[7:0] <= {1'b0, thr_sel_reg, pair_odd_sync_reg, pair_even_sync_reg,
                         channel_on_bit_reg};
        end
        `LSDPC_OFF_MAP: begin
          dat_o[7:0] <= map_reg;
        end
        `LSDPC_OFF_CFG2: begin
          dat_o[7:0] <= {iol_en_reg, 2'h0, thermal_warning_flag_reg, fast_slew_reg};
        end
        `LSDPC_OFF_DIAG: begin
          dat_o[8:0] <= {frame_error_flag_reg | frame_err_pending_reg, mode_o,
                         open_load_off_summary, uv_flag_reg, channel_fault_flag_reg}; // R4 R5
        end
        `LSDPC_OFF_OSM: begin
          dat_o[3:0] <= output_monitor_bit_reg; // R5
        end
        `LSDPC_OFF_RELEASE: begin
          dat_o[3:0] <= latch_release_bit_reg;
        end
        default: begin
          dat_o <= '0;
        end
      endcase
    end
  end

  //////////////////////////////
  // Control registers
  always_ff @(posedge clk_i) begin
    if (reg_rst) begin
      channel_on_bit_reg <= 4'h0; // R10
      pair_even_sync_reg <= 1'b0;
      pair_odd_sync_reg  <= 1'b0;
      thr_sel_reg        <= 1'b0;
    end else if (wr && hit(adr_i, `LSDPC_OFF_CTRL) && sel_i[0]) begin
      channel_on_bit_reg <= dat_i[3:0];
      pair_even_sync_reg <= dat_i[`LSDPC_CTRL_PAIR_EVEN];
      pair_odd_sync_reg  <= dat_i[`LSDPC_CTRL_PAIR_ODD];
      thr_sel_reg        <= dat_i[`LSDPC_CTRL_THR_SEL];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      soft_rst_reg <= 1'b0;
    end else begin
      soft_rst_reg <= wr & hit(adr_i, `LSDPC_OFF_CTRL) & sel_i[0] & dat_i[`LSDPC_CTRL_SOFT_RST]; // R8
    end
  end

  always_ff @(posedge clk_i) begin
    if (reg_rst) begin
      map_reg <= `LSDPC_MAP_DEFAULT; // R10
    end else if (wr && hit(adr_i, `LSDPC_OFF_MAP) && sel_i[0]) begin
      map_reg <= dat_i[7:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (reg_rst) begin
      fast_slew_reg <= 1'b0; // R11
      iol_en_reg    <= 4'h0;
    end else if (wr && hit(adr_i, `LSDPC_OFF_CFG2) && sel_i[0]) begin
      fast_slew_reg <= dat_i[`LSDPC_CFG2_FAST_SLEW]; // R11
      iol_en_reg    <= dat_i[7:4];
    end
  end

  assign fast_slew_select_o          = fast_slew_reg; // R11
  assign overload_threshold_select_o = thr_sel_reg; // R18

  //////////////////////////////
  // Status flags
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      thermal_warning_flag_reg <= 1'b0;
    end else if (temp_above_warn_i) begin
      thermal_warning_flag_reg <= 1'b1; // R20
    end else if (temp_below_hys_i) begin
      thermal_warning_flag_reg <= 1'b0; // R20
    end
  end

  always_ff @(posedge clk_i) begin
    if (flag_rst) begin
      uv_flag_reg <= 1'b0;
    end else if (vm_uv_i | failsafe_entry) begin
      uv_flag_reg <= 1'b1; // R17 R3
    end else if (rd_diag & vm_op_i) begin
      uv_flag_reg <= 1'b0; // R17
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      frame_err_pending_reg <= 1'b0;
    end else if (failsafe_entry) begin
      frame_err_pending_reg <= 1'b1; // R4
    end else if (access) begin
      frame_err_pending_reg <= 1'b0; // R4
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      frame_error_flag_reg <= 1'b0;
    end else if (frame_error_i | (access & frame_err_pending_reg & ~rd_diag)) begin
      frame_error_flag_reg <= 1'b1; // R4
    end else if (rd_diag) begin
      frame_error_flag_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      output_monitor_bit_reg <= 4'h0;
    end else begin
      output_monitor_bit_reg <= sense_i.vds_low; // R5
    end
  end

  assign open_load_off_summary = ~failsafe &
                                 (|(output_monitor_bit_reg & ~channel_gate_o & iol_en_reg)); // R5

  //////////////////////////////
  // Channels, pairing, release and retry
  assign demand    = failsafe ? {direct_input_pin_i, 2'b00} : // R7 R1
                     (channel_on_bit_reg | lsdpc_input_map(map_reg, direct_input_pin_i)); // R10
  assign pair_mask = {pair_odd_sync_reg, pair_even_sync_reg, pair_odd_sync_reg,
                      pair_even_sync_reg}; // R13
  assign partner_trip = pair_mask & {trip[1:0], trip[3:2]}; // R12 R14

  always_ff @(posedge clk_i) begin
    if (flag_rst) begin
      channel_fault_flag_reg <= 4'h0;
    end else begin
      channel_fault_flag_reg <= trip | (channel_fault_flag_reg & // R15 R9
                                ~({4{wr & hit(adr_i, `LSDPC_OFF_RELEASE) & sel_i[0]}} & dat_i[3:0]));
    end
  end

  always_ff @(posedge clk_i) begin
    if (reg_rst) begin
      latch_release_bit_reg <= 4'h0;
    end else begin
      latch_release_bit_reg <= (latch_release_bit_reg & latched) | // R16
                               ({4{wr & hit(adr_i, `LSDPC_OFF_RELEASE) & sel_i[0]}} & dat_i[3:0]);
    end
  end

  generate
    for (genvar i = 0; i < 4; i++) begin : g_ch
      lsdpc_channel #(
        .SYNC2_CYC  (SYNC2_CYC),
        .INRUSH_CYC (INRUSH_CYC),
        .OFF_OCP_CYC(OFF_OCP_CYC)
      ) u_channel (
        .clk_i         (clk_i),
        .rst_i         (flag_rst),
        .demand_i      (demand[i]),
        .oc_high_i     (sense_i.oc_high[i]),
        .oc_low_i      (sense_i.oc_low[i]),
        .over_temp_i   (sense_i.over_temp[i]),
        .release_i     (latch_release_bit_reg[i] | retry[i]), // R15 R21
        .partner_trip_i(partner_trip[i]),
        .gate_o        (channel_gate_o[i]),
        .trip_o        (trip[i]),
        .latched_o     (latched[i]),
        .high_thr_o    (high_threshold_o[i])
      );

      lsdpc_retry #(
        .BASE_CYC (RETRY_BASE_CYC),
        .SYNC2_CYC(SYNC2_CYC)
      ) u_retry (
        .clk_i       (clk_i),
        .rst_i       (rst_i),
        .enable_i    (failsafe),
        .input_high_i(demand[i]),
        .latched_i   (latched[i]),
        .retry_o     (retry[i])
      );
    end
  endgenerate
endmodule : lsdpc_top
`default_nettype wire

// ---- sim/lsdpc_load.sv ----
// Load model of the four switched outputs
`timescale 1ns/1ps
`default_nettype none
module lsdpc_load
  import lsdpc_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic [3:0] gate_i,
  input  wire logic [3:0] short_i,
  input  wire logic [3:0] hot_i,
  output var lsdpc_sense_type sense_o
);
  always_ff @(posedge clk_i) begin
    sense_o.oc_high   <= gate_i & short_i;
    sense_o.oc_low    <= gate_i & short_i;
    sense_o.over_temp <= hot_i;
    sense_o.vds_low   <= gate_i;
  end
endmodule : lsdpc_load
`default_nettype wire

// ---- sim/lsdpc_monitor.sv ----
// Port checker of the driver control block
`timescale 1ns/1ps
`default_nettype none
module lsdpc_monitor
  import lsdpc_pkg::*;
#(
  parameter int unsigned INRUSH_CYC = 8,
  parameter int unsigned SYNC2_CYC  = 4
) (
  input wire logic            clk_i,
  input wire logic            rst_i,
  input wire logic            cyc_i,
  input wire logic            stb_i,
  input wire logic            ack_o,
  input wire logic            sleep_bar_pin_i,
  input wire logic [1:0]      direct_input_pin_i,
  input wire lsdpc_sense_type sense_i,
  input wire logic [3:0]      channel_gate_o,
  input wire logic [3:0]      high_threshold_o,
  input wire logic            overload_threshold_select_o,
  input wire logic            fast_slew_select_o,
  input wire lsdpc_mode_type  mode_o
);
  logic [15:0] on_cnt_reg;
  logic [15:0] off_cnt_reg;
  logic        fs_w;
  assign fs_w = !sleep_bar_pin_i && (direct_input_pin_i != 2'h0);
  // On and off time of channel 0
  always_ff @(posedge clk_i) begin
    on_cnt_reg  <= (rst_i || !channel_gate_o[0]) ? 16'h0 : on_cnt_reg + 16'h1;
    off_cnt_reg <= (rst_i || channel_gate_o[0]) ? 16'h0 : off_cnt_reg + 16'h1;
  end
  //////////////////////////////
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  mode_set_a: assert property (fs_w |-> mode_o == LSDPC_MODE_FAILSAFE)
    else $error("fs mode");
  mode_clr_a: assert property (!fs_w |-> mode_o == LSDPC_MODE_NORMAL)
    else $error("normal mode");
  fs_low_off_a: assert property (fs_w[*3] |-> channel_gate_o[1:0] == 2'h0)
    else $error("low channel on");
  fs_follow_a: assert property (fs_w && $rose(channel_gate_o[2]) |-> $past(direct_input_pin_i[0]))
    else $error("ch2 no input");
  fs_regs_a: assert property (fs_w[*3] |-> !fast_slew_select_o && !overload_threshold_select_o)
    else $error("fs config");
  bus_ack_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("no ack");
  ack_pulse_a: assert property (ack_o |=> !ack_o)
    else $error("long ack");
  ot_trip_a: assert property (sense_i.over_temp[0] && channel_gate_o[0] |-> ##[1:2] !channel_gate_o[0])
    else $error("ot stays on");
  oc_trip_a: assert property ((sense_i.oc_high[1] && channel_gate_o[1])[*4] |-> ##[0:2] !channel_gate_o[1])
    else $error("oc stays on");
  inrush_lo_a: assert property (on_cnt_reg > INRUSH_CYC + 1 |-> !high_threshold_o[0])
    else $error("inrush thr");
  inrush_hi_a: assert property (off_cnt_reg > SYNC2_CYC + 1 |-> high_threshold_o[0])
    else $error("off thr");
  fs_entry_c: cover property (fs_w ##1 channel_gate_o[2]);
  trip_c: cover property ($fell(channel_gate_o[1]));
  bus_c: cover property (ack_o);
endmodule : lsdpc_monitor
bind lsdpc_top lsdpc_monitor #(.INRUSH_CYC(INRUSH_CYC), .SYNC2_CYC(SYNC2_CYC)) lsdpc_monitor_i (
  .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o),
  .sleep_bar_pin_i(sleep_bar_pin_i), .direct_input_pin_i(direct_input_pin_i),
  .sense_i(sense_i), .channel_gate_o(channel_gate_o), .high_threshold_o(high_threshold_o),
  .overload_threshold_select_o(overload_threshold_select_o),
  .fast_slew_select_o(fast_slew_select_o), .mode_o(mode_o));
`default_nettype wire

// ---- sim/tb_top.sv ----
// Self-checking bench of the driver control block
`timescale 1ns/1ps
`default_nettype none
`include "lsdpc_params.svh"
module tb_top;
  import lsdpc_pkg::*;
  localparam int unsigned BASE  = 20;
  localparam int unsigned SYNC2 = 4;
  logic            clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, sleep_bar_pin_i;
  logic            vm_uv_i, vm_op_i, temp_above_warn_i, temp_below_hys_i;
  logic            overload_threshold_select_o, fast_slew_select_o;
  logic [1:0]      direct_input_pin_i;
  logic [3:0]      sel_i, channel_gate_o, high_threshold_o, short_s, hot_s;
  logic [7:0]      adr_i;
  logic [31:0]     dat_i, dat_o;
  lsdpc_sense_type sense_i;
  lsdpc_mode_type  mode_o;
  int              error_cnt, checks, cyc_cnt;
  //////////////////////////////
  lsdpc_top #(.RETRY_BASE_CYC(BASE), .SYNC2_CYC(SYNC2), .INRUSH_CYC(8), .OFF_OCP_CYC(3))
    lsdpc_top_i (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .sleep_bar_pin_i(sleep_bar_pin_i), .direct_input_pin_i(direct_input_pin_i),
    .vdd_uv_i(1'b0), .vm_uv_i(vm_uv_i), .vm_op_i(vm_op_i), .frame_error_i(1'b0),
    .temp_above_warn_i(temp_above_warn_i), .temp_below_hys_i(temp_below_hys_i),
    .sense_i(sense_i), .channel_gate_o(channel_gate_o), .high_threshold_o(high_threshold_o),
    .overload_threshold_select_o(overload_threshold_select_o),
    .fast_slew_select_o(fast_slew_select_o), .mode_o(mode_o));
  lsdpc_load lsdpc_load_i (.clk_i(clk_i), .gate_i(channel_gate_o), .short_i(short_s),
    .hot_i(hot_s), .sense_o(sense_i));
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) cyc_cnt <= cyc_cnt + 1;
  //////////////////////////////
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic final_report();
    if (error_cnt == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : final_report
  task automatic bail(input string nm);
    check(nm, 32'h0, 32'h1);
    final_report();
  endtask : bail
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask : tick
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    int n = 0;
    {cyc_i, stb_i, we_i, adr_i, dat_i, sel_i} <= {2'h3, w, a, d, 4'hf};
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 20);
    if (n >= 20) bail("bus ack");
    q = dat_o;
    {cyc_i, stb_i, we_i} <= 3'h0;
    @(posedge clk_i);
  endtask : wb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask : wr
  task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] m, e);
    logic [31:0] q;
    wb(1'b0, a, 32'h0, q);
    check(nm, q & m, e);
  endtask : rd
  task automatic wait_g(input logic v);
    int n = 0;
    while (channel_gate_o[2] !== v && n < 2000) begin
      @(posedge clk_i);
      n++;
    end
    if (n >= 2000) bail("gate wait");
  endtask : wait_g
  task automatic gap(output int g);
    int t0;
    wait_g(1'b1);
    wait_g(1'b0);
    t0 = cyc_cnt;
    wait_g(1'b1);
    g = cyc_cnt - t0;
  endtask : gap
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_defaults();
    rd("ctrl", `LSDPC_OFF_CTRL, 32'hff, 32'h0);
    rd("map", `LSDPC_OFF_MAP, 32'hff, 32'h84);
    wr(8'h20, 32'hff);
    rd("unmapped", 8'h20, '1, 32'h0);
    check("slew", fast_slew_select_o, 1'b0);
  endtask : t_defaults
  task automatic t_slew();
    wr(`LSDPC_OFF_CFG2, 32'h1);
    check("fast slew", fast_slew_select_o, 1'b1);
    wr(`LSDPC_OFF_CTRL, 32'h41);
    check("thr select", overload_threshold_select_o, 1'b1);
    check("inrush thr", high_threshold_o[0], 1'b1);
    tick(12);
    check("late thr", high_threshold_o[0], 1'b0);
    wr(`LSDPC_OFF_CTRL, 32'h0);
    tick(SYNC2 + 4);
    check("thr back", high_threshold_o[0], 1'b1);
  endtask : t_slew
  task automatic t_trip();
    wr(`LSDPC_OFF_MAP, 32'h0);
    wr(`LSDPC_OFF_CTRL, 32'h2);
    check("gate on", channel_gate_o, 4'h2);
    short_s <= 4'h2;
    tick(12);
    short_s <= 4'h0;
    check("oc trip", channel_gate_o, 4'h0);
    rd("fault", `LSDPC_OFF_DIAG, 32'hf, 32'h2);
    wr(`LSDPC_OFF_CTRL, 32'h80);
    tick(2);
    rd("map back", `LSDPC_OFF_MAP, 32'hff, 32'h84);
    check("slew back", fast_slew_select_o, 1'b0);
    rd("kept", `LSDPC_OFF_DIAG, 32'hf, 32'h2);
    wr(`LSDPC_OFF_CTRL, 32'h2);
    tick(2);
    check("latched", channel_gate_o, 4'h0);
    wr(`LSDPC_OFF_RELEASE, 32'h2);
    tick(2);
    rd("release", `LSDPC_OFF_RELEASE, 32'hf, 32'h0);
    check("released", channel_gate_o, 4'h2);
    wr(`LSDPC_OFF_CTRL, 32'h0);
  endtask : t_trip
  task automatic t_pair();
    logic [3:0] m;
    for (int p = 0; p < 2; p++) begin
      m = 4'h5 << p;
      wr(`LSDPC_OFF_CTRL, 32'(m) | (32'h10 << p));
      check("pair on", channel_gate_o, m);
      if (p == 0) hot_s <= 4'h1;
      else short_s <= 4'h2;
      tick(12);
      check("pair off", channel_gate_o, 4'h0);
      rd("pair flag", `LSDPC_OFF_DIAG, 32'hf, 32'h1 << p);
      {hot_s, short_s} <= 8'h0;
      wr(`LSDPC_OFF_RELEASE, 32'(m));
      wr(`LSDPC_OFF_CTRL, 32'h0);
    end
  endtask : t_pair
  task automatic t_env();
    vm_op_i <= 1'b0;
    vm_uv_i <= 1'b1;
    tick(2);
    vm_uv_i <= 1'b0;
    rd("uv set", `LSDPC_OFF_DIAG, 32'h10, 32'h10);
    rd("uv held", `LSDPC_OFF_DIAG, 32'h10, 32'h10);
    vm_op_i <= 1'b1;
    rd("uv read", `LSDPC_OFF_DIAG, 32'h10, 32'h10);
    rd("uv clear", `LSDPC_OFF_DIAG, 32'h10, 32'h0);
    temp_above_warn_i <= 1'b1;
    tick(2);
    temp_above_warn_i <= 1'b0;
    rd("warn held", `LSDPC_OFF_CFG2, 32'h2, 32'h2);
    temp_below_hys_i <= 1'b1;
    tick(2);
    rd("warn clear", `LSDPC_OFF_CFG2, 32'h2, 32'h0);
    temp_below_hys_i <= 1'b0;
  endtask : t_env
  task automatic t_failsafe();
    int g;
    int lo;
    wr(`LSDPC_OFF_CFG2, 32'h1);
    wr(`LSDPC_OFF_CTRL, 32'h43);
    sleep_bar_pin_i <= 1'b0;
    direct_input_pin_i <= 2'h1;
    tick(4);
    check("mode", mode_o, LSDPC_MODE_FAILSAFE);
    check("fs gates", channel_gate_o, 4'h4);
    check("fs slew", fast_slew_select_o, 1'b0);
    rd("fs diag", `LSDPC_OFF_DIAG, 32'h1f0, 32'h150);
    rd("fs frame", `LSDPC_OFF_DIAG, 32'h100, 32'h0);
    rd("fs monitor", `LSDPC_OFF_OSM, 32'hf, 32'h4);
    wr(`LSDPC_OFF_CFG2, 32'h1);
    rd("fs cfg2", `LSDPC_OFF_CFG2, 32'h1, 32'h0);
    rd("fs ctrl", `LSDPC_OFF_CTRL, 32'hff, 32'h0);
    direct_input_pin_i <= 2'h3;
    tick(3);
    check("fs both", channel_gate_o, 4'hc);
    short_s <= 4'h4;
    for (int k = 0; k < 25; k++) begin
      gap(g);
      lo = BASE << (k / 8);
      check("gap", 32'(g >= lo && g <= lo + 4), 32'h1);
    end
    direct_input_pin_i <= 2'h2;
    tick(SYNC2 + 3);
    direct_input_pin_i <= 2'h3;
    gap(g);
    check("restart", 32'(g >= BASE && g <= BASE + 4), 32'h1);
    short_s <= 4'h0;
    direct_input_pin_i <= 2'h0;
    sleep_bar_pin_i <= 1'b1;
    tick(2);
    check("normal", mode_o, LSDPC_MODE_NORMAL);
  endtask : t_failsafe
  //////////////////////////////
  initial begin
    repeat (100000) @(posedge clk_i);
    bail("run time");
  end
  initial begin
    {rst_i, vm_op_i, sleep_bar_pin_i} = 3'h7;
    {cyc_i, stb_i, we_i, vm_uv_i, temp_above_warn_i, temp_below_hys_i} = 6'h0;
    {adr_i, sel_i, dat_i, direct_input_pin_i} = 46'h0;
    {short_s, hot_s} = 8'h0;
    {error_cnt, checks, cyc_cnt} = '0;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_defaults();
    t_slew();
    t_trip();
    t_pair();
    t_env();
    t_failsafe();
    final_report();
  end
endmodule : tb_top
`default_nettype wire
